// ---- hw/reset_source_combiner.sv ----
`timescale 1ns/100ps
// Contract
// - In NORMAL or HALT, power-on or brownout gives full system reset.
// - In NORMAL or HALT, watchdog time-out set for reset gives full reset.
// - In NORMAL or HALT, external reset pin gives full system reset.
// - In STOP, power-on or brownout still gives full system reset.
// - In STOP, external reset pin gives full system reset.
// - In STOP, debug pin driven low gives full system reset.
// - In STOP, watchdog reset time-out starts recovery, sets watchdog and stop flags.
// - After supply release hold 66 oscillator then 16 clock cycles, set power-on flag.
module reset_source_combiner (
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   // Reset sources
   input  wire reset_combiner_pkg::reset_src_type     resetSrc,
   input  wire logic                                  oscTick,
   input  wire logic                                  debugResetReq,
   input  wire reset_combiner_pkg::op_mode_type       opMode,
   // Reset outputs
   output logic                                       sysReset,
   output logic                                       debugReset,
   output logic                                       stopRecovery,
   output reset_combiner_pkg::reset_status_type       status
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reset_combiner_pkg::reset_src_type    srcMeta_r;
   reset_combiner_pkg::reset_src_type    src_r;
   logic                                 oscMeta_r;
   logic                                 osc_r;
   logic                                 oscPrev_r;
   logic                                 oscEdge;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         srcMeta_r <= '{supplyLow: 1'b1, debugPin: 1'b1, default: 1'b0};
         src_r     <= '{supplyLow: 1'b1, debugPin: 1'b1, default: 1'b0};
         oscMeta_r <= 1'b0;
         osc_r     <= 1'b0;
         oscPrev_r <= 1'b0;
      end else begin
         srcMeta_r <= resetSrc;
         src_r     <= srcMeta_r;
         oscMeta_r <= oscTick;
         osc_r     <= oscMeta_r;
         oscPrev_r <= osc_r;
      end
   end

   assign oscEdge = osc_r & ~oscPrev_r;

   // ----------------------------------------------------------------
   // Power-on delay
   // ----------------------------------------------------------------
   logic porHold;
   logic porDone;

   por_delay por_delay_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .supplyLow (src_r.supplyLow),
      .oscTick   (oscEdge),
      .porHold   (porHold),
      .porDone   (porDone)
   );

   // ----------------------------------------------------------------
   // Combining
   // ----------------------------------------------------------------
   logic                                  isStop;
   logic                                  wdtReset;
   logic                                  fullReq;
   logic                                  sysReset_nxt;
   logic                                  debugReset_nxt;
   logic                                  stopRecovery_nxt;
   logic                                  wdtPrev_r;
   logic                                  wdtEdge;
   reset_combiner_pkg::reset_status_type  status_nxt;

   assign isStop   = (opMode == reset_combiner_pkg::MODE_STOP);
   assign wdtReset = src_r.watchdogTimeout & src_r.watchdogResetSel;
   assign wdtEdge  = wdtReset & ~wdtPrev_r;

   always_comb begin
      fullReq = porHold | src_r.resetPin;
      if (isStop) begin
         fullReq = fullReq | ~src_r.debugPin;
      end else begin
         fullReq = fullReq | wdtReset;
      end
      debugReset_nxt   = fullReq;
      sysReset_nxt     = fullReq | debugResetReq;
      stopRecovery_nxt = isStop & wdtEdge;
      status_nxt       = status;
      if (porDone) begin
         status_nxt.porFlag = 1'b1;
      end
      if (wdtEdge) begin
         status_nxt.wdtFlag = 1'b1;
         if (isStop) begin
            status_nxt.stopFlag = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sysReset     <= 1'b1;
         debugReset   <= 1'b1;
         stopRecovery <= 1'b0;
         wdtPrev_r    <= 1'b0;
         status       <= '0;
      end else begin
         sysReset     <= sysReset_nxt;
         debugReset   <= debugReset_nxt;
         stopRecovery <= stopRecovery_nxt;
         wdtPrev_r    <= wdtReset;
         status       <= status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   pin_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
      src_r.resetPin |=> sysReset && debugReset)
      else $error("Reset pin did not reset the system.");

   debug_only_a: assert property (@(posedge clk) disable iff (!reset_n)
      debugResetReq && !fullReq |=> sysReset && !debugReset)
      else $error("Debugger reset handled wrongly.");

   stop_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      isStop && !src_r.debugPin |=> sysReset)
      else $error("Debug pin low in stop did not reset.");

   wdt_normal_a: assert property (@(posedge clk) disable iff (!reset_n)
      !isStop && wdtReset |=> sysReset)
      else $error("Watchdog reset missing.");

   wdt_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      isStop && wdtEdge |=> stopRecovery && status.wdtFlag && status.stopFlag)
      else $error("Stop recovery not started.");

   supply_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      src_r.supplyLow |=> ##1 sysReset)
      else $error("Supply low did not hold reset.");

   por_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      porDone |=> status.porFlag && (!sysReset || $past(fullReq || debugResetReq)))
      else $error("Power-on flag not set at release.");

   stop_supply_a: assert property (@(posedge clk) disable iff (!reset_n)
      isStop && porHold |=> sysReset)
      else $error("Supply reset lost in stop.");

   combine_a: assert property (@(posedge clk) disable iff (!reset_n)
      !fullReq && !debugResetReq |=> !sysReset)
      else $error("System reset without a source.");

   stop_wdt_noreset_a: assert property (@(posedge clk) disable iff (!reset_n)
      isStop && wdtReset && !porHold && !src_r.resetPin && src_r.debugPin
      && !debugResetReq |=> !sysReset)
      else $error("Watchdog in stop reset the system.");

   recovery_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      stopRecovery |=> !stopRecovery)
      else $error("Stop recovery longer than one cycle.");

   stop_pin_rst_a: assert property (@(posedge clk) disable iff (!reset_n)
      isStop && src_r.resetPin |=> sysReset && debugReset)
      else $error("Reset pin in stop did not reset.");

   debug_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
      !fullReq |=> !debugReset)
      else $error("Debug logic reset by the debugger source.");

   por_release_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(porHold) |-> porDone)
      else $error("Power-on hold ended without done.");

endmodule // reset_source_combiner

// ---- common/reset_combiner_pkg.sv ----
package reset_combiner_pkg;

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int unsigned POR_WDOSC_CYCLES = 66;
   localparam int unsigned POR_SYSCLK_CYCLES = 16;
   localparam int unsigned CNT_WIDTH = 7;

   // ----------------------------------------------------------------
   // Debug control bit position
   // ----------------------------------------------------------------
   localparam int unsigned DBG_RESET_BIT = 0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_HALT,
      MODE_STOP
   } op_mode_type;

   typedef struct packed {
      logic supplyLow;
      logic watchdogTimeout;
      logic watchdogResetSel;
      logic resetPin;
      logic debugPin;
   } reset_src_type;

   typedef struct packed {
      logic porFlag;
      logic wdtFlag;
      logic stopFlag;
   } reset_status_type;

endpackage

// ---- hw/por_delay.sv ----
`timescale 1ns/100ps
module por_delay #(
   parameter int unsigned OSC_CYCLES = reset_combiner_pkg::POR_WDOSC_CYCLES,
   parameter int unsigned CLK_CYCLES = reset_combiner_pkg::POR_SYSCLK_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control
   input  wire logic supplyLow,
   input  wire logic oscTick,
   // Status
   output logic      porHold,
   output logic      porDone
);

   typedef enum logic [1:0] {S_HOLD, S_OSC, S_CLK, S_RUN} por_state_type;

   localparam int unsigned CNT_WIDTH = reset_combiner_pkg::CNT_WIDTH;

   por_state_type                                state_r;
   por_state_type                                state_nxt;
   logic [reset_combiner_pkg::CNT_WIDTH-1:0]     count_r;
   logic [reset_combiner_pkg::CNT_WIDTH-1:0]     count_nxt;
   logic                                         done_nxt;

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      done_nxt  = 1'b0;
      if (supplyLow) begin
         state_nxt = S_HOLD;
         count_nxt = '0;
      end else begin
         unique case (state_r)
            S_HOLD: begin
               state_nxt = S_OSC;
               count_nxt = '0;
            end
            S_OSC: begin
               if (oscTick) begin
                  if (count_r == CNT_WIDTH'(OSC_CYCLES - 1)) begin
                     state_nxt = S_CLK;
                     count_nxt = '0;
                  end else begin
                     count_nxt = count_r + CNT_WIDTH'(1);
                  end
               end
            end
            S_CLK: begin
               if (count_r == CNT_WIDTH'(CLK_CYCLES - 1)) begin
                  state_nxt = S_RUN;
                  done_nxt  = 1'b1;
               end else begin
                  count_nxt = count_r + CNT_WIDTH'(1);
               end
            end
            S_RUN: begin
               state_nxt = S_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= S_HOLD;
         count_r <= '0;
         porDone <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         porDone <= done_nxt;
      end
   end

   assign porHold = (state_r != S_RUN);

endmodule // por_delay

// ---- verif/supply_pin_model.sv ----
`timescale 1ns/100ps
module supply_pin_model (
   // Commands from the bench
   input  wire logic                          supplyLowCmd,
   input  wire logic                          pinCmd,
   input  wire logic                          dbgLowCmd,
   input  wire logic                          wdtCmd,
   input  wire logic                          wdtSelCmd,
   // Reset sources
   output reset_combiner_pkg::reset_src_type  resetSrc,
   output logic                               oscTick
);
   // ----------------------------------------------------------------
   // Watchdog oscillator
   // ----------------------------------------------------------------
   // The oscillator runs free, one period is four system clocks.
   initial begin
      oscTick = 1'b0;
      forever #40 oscTick = ~oscTick;
   end
   // ----------------------------------------------------------------
   // Pins and supply monitor
   // ----------------------------------------------------------------
   assign resetSrc = '{supplyLowCmd, wdtCmd, wdtSelCmd, pinCmd, ~dbgLowCmd};
endmodule // supply_pin_model

// ---- verif/reset_source_combiner_test.sv ----
`timescale 1ns/100ps
module reset_source_combiner_test;
   logic                                  clk;
   logic                                  reset_n;
   logic                                  supplyLowCmd, pinCmd, dbgLowCmd, wdtCmd, wdtSelCmd;
   logic                                  debugResetReq;
   reset_combiner_pkg::op_mode_type       opMode;
   reset_combiner_pkg::reset_src_type     resetSrc;
   logic                                  oscTick, sysReset, debugReset, stopRecovery;
   reset_combiner_pkg::reset_status_type  status;
   int                                    n_fail, checks, cnt;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   supply_pin_model supply_pin_model_inst (.supplyLowCmd(supplyLowCmd), .pinCmd(pinCmd),
      .dbgLowCmd(dbgLowCmd), .wdtCmd(wdtCmd), .wdtSelCmd(wdtSelCmd), .resetSrc(resetSrc),
      .oscTick(oscTick));

   reset_source_combiner reset_source_combiner_inst (.clk(clk), .reset_n(reset_n),
      .resetSrc(resetSrc), .oscTick(oscTick), .debugResetReq(debugResetReq), .opMode(opMode),
      .sysReset(sysReset), .debugReset(debugReset), .stopRecovery(stopRecovery),
      .status(status));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Expected {sysReset, debugReset} from the commanded sources.
   function automatic logic [1:0] expect_rst();
      logic full;
      full = supplyLowCmd | pinCmd
         | (opMode != reset_combiner_pkg::MODE_STOP & wdtCmd & wdtSelCmd)
         | (opMode == reset_combiner_pkg::MODE_STOP & dbgLowCmd);
      return {full | debugResetReq, full};
   endfunction

   // Waits for the power-on hold to end and checks its length.
   task automatic por_wait();
      cnt = 0;
      while (sysReset !== 1'b0 && cnt < 2000) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= 2000) begin
         n_fail++;
         final_report();
      end
      check(8'({cnt >= 65 * 4 + 16, cnt <= 66 * 4 + 16 + 10}), 8'h03);
      check(8'(status.porFlag), 8'h01);
   endtask

   initial begin
      n_fail = 0;
      checks = 0;
      reset_n = 1'b0;
      {supplyLowCmd, pinCmd, dbgLowCmd, wdtCmd, wdtSelCmd, debugResetReq} = 6'h20;
      opMode = reset_combiner_pkg::MODE_NORMAL;
      void'($urandom(32'hd9596a7a));
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      supplyLowCmd = 1'b0;
      por_wait();
      // Watchdog reset time-out in STOP gives recovery, not reset.
      opMode = reset_combiner_pkg::MODE_STOP;
      wdtSelCmd = 1'b1;
      @(negedge clk);
      wdtCmd = 1'b1;
      cnt = 0;
      while (stopRecovery !== 1'b1 && cnt < 8) begin
         @(negedge clk);
         cnt++;
      end
      if (stopRecovery !== 1'b1) begin
         n_fail++;
         final_report();
      end
      check(8'(stopRecovery), 8'h01);
      @(negedge clk);
      check(8'({stopRecovery, sysReset, status.wdtFlag, status.stopFlag}), 8'h03);
      wdtCmd = 1'b0;
      // Random sources and modes.
      for (int i = 0; i < 300; i++) begin
         {pinCmd, dbgLowCmd, wdtCmd, wdtSelCmd, debugResetReq} = 5'($urandom);
         opMode = reset_combiner_pkg::op_mode_type'(2'($urandom % 3));
         repeat (4) @(negedge clk);
         check(8'({sysReset, debugReset}), 8'(expect_rst()));
      end
      // Brownout in STOP.
      {pinCmd, dbgLowCmd, wdtCmd, debugResetReq} = 4'h0;
      opMode = reset_combiner_pkg::MODE_STOP;
      supplyLowCmd = 1'b1;
      repeat (4) @(negedge clk);
      check(8'({sysReset, debugReset}), 8'h03);
      supplyLowCmd = 1'b0;
      por_wait();
      final_report();
   end
endmodule // reset_source_combiner_test
